/* diag_channel.sv */
// Purpose: One channel's information values and diagnostic flags
// Assumes: Measurements come from logic on the same clock
// Notes: All outputs are registered, one cycle behind the inputs
`timescale 1ns/1ps
module diag_channel
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Live measurements
	input wire logic [15:0] status_word,
	input wire logic [15:0] coil_voltage,
	input wire logic [15:0] coil_current,
	input wire logic [15:0] current_limit,
	input wire logic [15:0] control_error,
	input wire logic [7:0] duty_cycle,
	input wire logic [15:0] motor_velocity,
	input wire logic [15:0] overload_time,
	input wire logic [15:0] pos_status,
	input wire logic [15:0] pos_step,
	input wire logic [15:0] pos_lag,
	input wire logic [3:0] active_mode,
	input wire logic [7:0] temperature_c,
	input wire logic [15:0] supply_mv,
	input wire logic short_detect,
	input wire logic stage_unpowered,
	input wire logic init_failed,
	// Active configuration
	input wire logic [15:0] nominal_current,
	input wire logic [15:0] nominal_voltage,
	input wire logic overload_is_error,
	input wire logic config_pending,
	// Registered results
	output logic [15:0] info_reg [11],
	output logic [motor_diag_pkg::FLG_W-1:0] flags_reg,
	output logic [3:0] mode_reg,
	output logic warn_reg,
	output logic err_reg
);

	logic [15:0] cur_mag;
	logic torque;
	logic [motor_diag_pkg::FLG_W-1:0] flags_next;

	// Current magnitude for the overload compare
	assign cur_mag = coil_current[15] ? 16'(-coil_current) : coil_current;
	assign torque = cur_mag > nominal_current;

	// Flag evaluation
	always_comb
	begin
		flags_next = '0;
		flags_next[motor_diag_pkg::FLG_SATURATED] = ($signed(duty_cycle) >= motor_diag_pkg::DUTY_SAT_POS)
			|| ($signed(duty_cycle) <= motor_diag_pkg::DUTY_SAT_NEG);
		flags_next[motor_diag_pkg::FLG_OVERTEMP] = $signed(temperature_c) > motor_diag_pkg::TEMP_WARN_C;
		flags_next[motor_diag_pkg::FLG_TORQUE] = torque;
		flags_next[motor_diag_pkg::FLG_UNDERVOLT] = supply_mv < motor_diag_pkg::UNDERVOLT_MV;
		// supply above nominal plus a tenth
		flags_next[motor_diag_pkg::FLG_OVERVOLT] =
			({4'h0, supply_mv} * motor_diag_pkg::OVERVOLT_DEN) >
			({4'h0, nominal_voltage} * motor_diag_pkg::OVERVOLT_NUM);
		flags_next[motor_diag_pkg::FLG_SHORT] = short_detect;
		flags_next[motor_diag_pkg::FLG_NO_POWER] = stage_unpowered;
		// init, hot or overload as error
		flags_next[motor_diag_pkg::FLG_MISC] = init_failed
			|| ($signed(temperature_c) > motor_diag_pkg::TEMP_ERR_C)
			|| (torque && overload_is_error);
		flags_next[motor_diag_pkg::FLG_CONFIG] = config_pending;
	end

	// live info values, zero after reset except step
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			info_reg <= '{default: 16'h0000};
			// step reads all ones after reset
			info_reg[9] <= motor_diag_pkg::POS_STEP_RST;
		end
		else
		begin
			info_reg[0] <= status_word;
			info_reg[1] <= coil_voltage;
			info_reg[2] <= coil_current;
			info_reg[3] <= current_limit;
			info_reg[4] <= control_error;
			info_reg[5] <= {{8{duty_cycle[7]}}, duty_cycle};
			info_reg[6] <= motor_velocity;
			info_reg[7] <= overload_time;
			info_reg[8] <= pos_status;
			info_reg[9] <= pos_step;
			info_reg[10] <= pos_lag;
		end
	end

	// Flags, mode and summary bits
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			flags_reg <= '0;
			mode_reg <= 4'h0;
			warn_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			flags_reg <= flags_next;
			mode_reg <= active_mode;
			warn_reg <= flags_next[motor_diag_pkg::FLG_SATURATED]
				| flags_next[motor_diag_pkg::FLG_OVERTEMP]
				| (torque & ~overload_is_error) | config_pending;
			err_reg <= |flags_next[motor_diag_pkg::FLG_MISC:motor_diag_pkg::FLG_UNDERVOLT]
				| (torque & overload_is_error);
		end
	end

endmodule

/* motor_diag_pkg.sv */
// Purpose: Shared constants for the two-channel motor diagnostic register bank
// Assumes: APB with 32-bit data, 12-bit byte address, one aligned word per register
// Notes: Channel blocks sit at channel * CH_STRIDE from address 0
package motor_diag_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 2;
	localparam logic [11:0] CH_STRIDE = 12'h040;
	localparam logic [11:0] GLB_BASE = 12'h080;

	// ==========================================================
	// Per-channel word offsets
	localparam logic [5:0] OFF_STATUS_COPY = 6'h00;
	localparam logic [5:0] OFF_COIL_VOLTAGE = 6'h04;
	localparam logic [5:0] OFF_COIL_CURRENT = 6'h08;
	localparam logic [5:0] OFF_CURRENT_LIMIT = 6'h0c;
	localparam logic [5:0] OFF_CONTROL_ERROR = 6'h10;
	localparam logic [5:0] OFF_DUTY_CYCLE = 6'h14;
	localparam logic [5:0] OFF_MOTOR_VELOCITY = 6'h18;
	localparam logic [5:0] OFF_OVERLOAD_TIME = 6'h1c;
	localparam logic [5:0] OFF_POS_STATUS = 6'h20;
	localparam logic [5:0] OFF_POS_STEP = 6'h24;
	localparam logic [5:0] OFF_POS_LAG = 6'h28;
	localparam logic [5:0] OFF_DIAG_FLAGS = 6'h2c;
	localparam logic [5:0] OFF_NOM_CURRENT = 6'h30;
	localparam logic [5:0] OFF_NOM_VOLTAGE = 6'h34;
	localparam logic [5:0] OFF_CFG_CTRL = 6'h38;
	localparam logic [5:0] OFF_ADOPT = 6'h3c;

	// ==========================================================
	// Global interrupt word offsets
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h080;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h084;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h088;
	localparam int IRQ_W = 4;

	// ==========================================================
	// Diagnostic flag bit positions
	localparam int FLG_SATURATED = 0;
	localparam int FLG_OVERTEMP = 1;
	localparam int FLG_TORQUE = 2;
	localparam int FLG_UNDERVOLT = 3;
	localparam int FLG_OVERVOLT = 4;
	localparam int FLG_SHORT = 5;
	localparam int FLG_NO_POWER = 7;
	localparam int FLG_MISC = 8;
	localparam int FLG_CONFIG = 9;
	localparam int FLG_W = 10;
	localparam int MODE_LSB = 16;

	// ==========================================================
	// Thresholds, in degrees Celsius, millivolts, a ratio and duty counts
	localparam logic signed [7:0] TEMP_WARN_C = 8'sh50;
	localparam logic signed [7:0] TEMP_ERR_C = 8'sh64;
	localparam logic [15:0] UNDERVOLT_MV = 16'h1b58;
	localparam logic [19:0] OVERVOLT_NUM = 20'h0000b;
	localparam logic [19:0] OVERVOLT_DEN = 20'h0000a;
	localparam logic signed [7:0] DUTY_SAT_POS = 8'sh7f;
	localparam logic signed [7:0] DUTY_SAT_NEG = 8'sh81;

	// ==========================================================
	// Values after reset
	localparam logic [15:0] POS_STEP_RST = 16'hffff;
	localparam logic [15:0] NOM_CURRENT_RST = 16'h03e8;
	localparam logic [15:0] NOM_VOLTAGE_RST = 16'h5dc0;

endpackage

/* motor_diag_regs.sv */
// Purpose: APB register bank of motor channel information and diagnostics
// Assumes: Measurement inputs come from logic on the same clock
// Notes: Zero wait-state reads, unmapped words answer with pslverr
// Overview of operation
// - Saturation flag while duty is at 127 or at -127 and below
// - Over-temperature flag above 80 degrees
// - Torque overload; warning or error by config
// - Under-voltage error below 7 V
// - Over-voltage error above nominal plus 10 %
// - Short-circuit error from driver stage
// - Missing-power error while stage unpowered
// - Misc error: init fail, 100 degrees, overload
// - Config flag while written setting not adopted
// - Four-bit active operating mode field
// - Positioning step reads 0xffff after reset
// - Status word copy readable per channel
`timescale 1ns/1ps
module motor_diag_regs
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Per-channel measurements, index 0 is channel 1
	input wire logic [1:0][15:0] status_word,
	input wire logic [1:0][15:0] coil_voltage,
	input wire logic [1:0][15:0] coil_current,
	input wire logic [1:0][15:0] current_limit,
	input wire logic [1:0][15:0] control_error,
	input wire logic [1:0][7:0] duty_cycle,
	input wire logic [1:0][15:0] motor_velocity,
	input wire logic [1:0][15:0] overload_time,
	input wire logic [1:0][15:0] pos_status,
	input wire logic [1:0][15:0] pos_step,
	input wire logic [1:0][15:0] pos_lag,
	input wire logic [1:0][3:0] active_mode,
	input wire logic [1:0][7:0] temperature_c,
	input wire logic [1:0][15:0] supply_mv,
	input wire logic [1:0] short_detect,
	input wire logic [1:0] stage_unpowered,
	input wire logic [1:0] init_failed,
	// Interrupt
	output logic irq
);

	// ==========================================================
	// Declarations

	// Bus answer registers
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic irq_reg;

	// Decode and read path
	logic setup;
	logic wr_fire;
	logic ch_sel;
	logic in_ch_area;
	logic in_glb_area;
	logic hit;
	logic [5:0] ch_off;
	logic [31:0] rd_data;

	// Written and adopted configuration copies
	logic [1:0][15:0] nom_cur_shadow_reg;
	logic [1:0][15:0] nom_cur_active_reg;
	logic [1:0][15:0] nom_volt_shadow_reg;
	logic [1:0][15:0] nom_volt_active_reg;
	logic [1:0] ovl_err_shadow_reg;
	logic [1:0] ovl_err_active_reg;
	logic [1:0] cfg_pending;

	// Channel results and summary history
	logic [15:0] info [2][11];
	logic [motor_diag_pkg::FLG_W-1:0] flags [2];
	logic [3:0] mode [2];
	logic [1:0] warn;
	logic [1:0] err;
	logic [1:0] warn_prev_reg;
	logic [1:0] err_prev_reg;

	// Interrupt state
	logic [motor_diag_pkg::IRQ_W-1:0] irq_status_reg;
	logic [motor_diag_pkg::IRQ_W-1:0] irq_enable_reg;
	logic [motor_diag_pkg::IRQ_W-1:0] irq_events;
	logic [motor_diag_pkg::IRQ_W-1:0] irq_clear;

	// ==========================================================
	// Output wiring

	// Ports straight from flip-flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	// ==========================================================
	// Channel instances

	for (genvar g = 0; g < motor_diag_pkg::NUM_CH; g++)
	begin : gen_ch
		diag_channel u_ch
		(
			.clock(clock),
			.rst_n(rst_n),
			.status_word(status_word[g]),
			.coil_voltage(coil_voltage[g]),
			.coil_current(coil_current[g]),
			.current_limit(current_limit[g]),
			.control_error(control_error[g]),
			.duty_cycle(duty_cycle[g]),
			.motor_velocity(motor_velocity[g]),
			.overload_time(overload_time[g]),
			.pos_status(pos_status[g]),
			.pos_step(pos_step[g]),
			.pos_lag(pos_lag[g]),
			.active_mode(active_mode[g]),
			.temperature_c(temperature_c[g]),
			.supply_mv(supply_mv[g]),
			.short_detect(short_detect[g]),
			.stage_unpowered(stage_unpowered[g]),
			.init_failed(init_failed[g]),
			.nominal_current(nom_cur_active_reg[g]),
			.nominal_voltage(nom_volt_active_reg[g]),
			.overload_is_error(ovl_err_active_reg[g]),
			.config_pending(cfg_pending[g]),
			.info_reg(info[g]),
			.flags_reg(flags[g]),
			.mode_reg(mode[g]),
			.warn_reg(warn[g]),
			.err_reg(err[g])
		);
	end

	// ==========================================================
	// Address decode

	// Phase qualifiers
	assign setup = psel & ~penable;
	assign wr_fire = psel & penable & pready_reg & pwrite;

	// Channel area, channel select and word offset
	assign in_ch_area = (paddr < motor_diag_pkg::GLB_BASE) && (paddr[1:0] == 2'b00);
	assign ch_sel = paddr[6];
	assign ch_off = paddr[5:0];
	assign in_glb_area = (paddr == motor_diag_pkg::OFF_IRQ_STATUS)
		|| (paddr == motor_diag_pkg::OFF_IRQ_CLEAR)
		|| (paddr == motor_diag_pkg::OFF_IRQ_ENABLE);
	assign hit = in_ch_area | in_glb_area;

	// ==========================================================
	// Read multiplexer

	// Selected word, zero above the field
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (in_ch_area)
		begin
			case (ch_off)
				motor_diag_pkg::OFF_STATUS_COPY: rd_data = {16'h0000, info[ch_sel][0]};
				motor_diag_pkg::OFF_COIL_VOLTAGE: rd_data = {16'h0000, info[ch_sel][1]};
				motor_diag_pkg::OFF_COIL_CURRENT: rd_data = {16'h0000, info[ch_sel][2]};
				motor_diag_pkg::OFF_CURRENT_LIMIT: rd_data = {16'h0000, info[ch_sel][3]};
				motor_diag_pkg::OFF_CONTROL_ERROR: rd_data = {16'h0000, info[ch_sel][4]};
				motor_diag_pkg::OFF_DUTY_CYCLE: rd_data = {24'h000000, info[ch_sel][5][7:0]};
				motor_diag_pkg::OFF_MOTOR_VELOCITY: rd_data = {16'h0000, info[ch_sel][6]};
				motor_diag_pkg::OFF_OVERLOAD_TIME: rd_data = {16'h0000, info[ch_sel][7]};
				motor_diag_pkg::OFF_POS_STATUS: rd_data = {16'h0000, info[ch_sel][8]};
				motor_diag_pkg::OFF_POS_STEP: rd_data = {16'h0000, info[ch_sel][9]};
				motor_diag_pkg::OFF_POS_LAG: rd_data = {16'h0000, info[ch_sel][10]};
				motor_diag_pkg::OFF_DIAG_FLAGS:
				begin
					rd_data[motor_diag_pkg::FLG_W-1:0] = flags[ch_sel];
					rd_data[motor_diag_pkg::MODE_LSB+:4] = mode[ch_sel];
				end
				motor_diag_pkg::OFF_NOM_CURRENT: rd_data = {16'h0000, nom_cur_shadow_reg[ch_sel]};
				motor_diag_pkg::OFF_NOM_VOLTAGE: rd_data = {16'h0000, nom_volt_shadow_reg[ch_sel]};
				motor_diag_pkg::OFF_CFG_CTRL: rd_data = {31'h0, ovl_err_shadow_reg[ch_sel]};
				default: rd_data = 32'h0000_0000;
			endcase
		end
		else if (paddr == motor_diag_pkg::OFF_IRQ_STATUS)
		begin
			rd_data = {28'h0, irq_status_reg};
		end
		else if (paddr == motor_diag_pkg::OFF_IRQ_ENABLE)
		begin
			rd_data = {28'h0, irq_enable_reg};
		end
	end

	// ==========================================================
	// APB answer

	// Ready in the access phase, data loaded in setup
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~hit;
			prdata_reg <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Configuration, shadow and active copies

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			nom_cur_shadow_reg <= {2{motor_diag_pkg::NOM_CURRENT_RST}};
			nom_volt_shadow_reg <= {2{motor_diag_pkg::NOM_VOLTAGE_RST}};
			ovl_err_shadow_reg <= 2'b00;
		end
		else if (wr_fire && in_ch_area)
		begin
			case (ch_off)
				motor_diag_pkg::OFF_NOM_CURRENT: nom_cur_shadow_reg[ch_sel] <= pwdata[15:0];
				motor_diag_pkg::OFF_NOM_VOLTAGE: nom_volt_shadow_reg[ch_sel] <= pwdata[15:0];
				motor_diag_pkg::OFF_CFG_CTRL: ovl_err_shadow_reg[ch_sel] <= pwdata[0];
				default: ;
			endcase
		end
	end

	// Adopt copies shadow into active
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			nom_cur_active_reg <= {2{motor_diag_pkg::NOM_CURRENT_RST}};
			nom_volt_active_reg <= {2{motor_diag_pkg::NOM_VOLTAGE_RST}};
			ovl_err_active_reg <= 2'b00;
		end
		else if (wr_fire && in_ch_area && ch_off == motor_diag_pkg::OFF_ADOPT && pwdata[0])
		begin
			nom_cur_active_reg[ch_sel] <= nom_cur_shadow_reg[ch_sel];
			nom_volt_active_reg[ch_sel] <= nom_volt_shadow_reg[ch_sel];
			ovl_err_active_reg[ch_sel] <= ovl_err_shadow_reg[ch_sel];
		end
	end

	// pending while shadow differs from active
	always_comb
	begin
		for (int c = 0; c < motor_diag_pkg::NUM_CH; c++)
		begin
			cfg_pending[c] = (nom_cur_shadow_reg[c] != nom_cur_active_reg[c])
				|| (nom_volt_shadow_reg[c] != nom_volt_active_reg[c])
				|| (ovl_err_shadow_reg[c] != ovl_err_active_reg[c]);
		end
	end

	// ==========================================================
	// Interrupts

	// Rising warning and error summaries
	assign irq_events = {err[1] & ~err_prev_reg[1], warn[1] & ~warn_prev_reg[1],
		err[0] & ~err_prev_reg[0], warn[0] & ~warn_prev_reg[0]};

	// Write-one-to-clear strobe
	assign irq_clear = (wr_fire && paddr == motor_diag_pkg::OFF_IRQ_CLEAR)
		? pwdata[motor_diag_pkg::IRQ_W-1:0] : '0;

	// Edge history
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			warn_prev_reg <= 2'b00;
			err_prev_reg <= 2'b00;
		end
		else
		begin
			warn_prev_reg <= warn;
			err_prev_reg <= err;
		end
	end

	// Sticky status, a new event beats the clear
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			irq_status_reg <= '0;
		end
		else
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
		end
	end

	// Enable mask
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			irq_enable_reg <= '0;
		end
		else if (wr_fire && paddr == motor_diag_pkg::OFF_IRQ_ENABLE)
		begin
			irq_enable_reg <= pwdata[motor_diag_pkg::IRQ_W-1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= |(irq_status_reg & irq_enable_reg);
		end
	end

endmodule

/* motor_diag_regs_props.sv */
// Purpose: Port checks of the motor diagnostic register bank
// Assumes: APB access cycle follows setup, flags one cycle behind inputs
// Notes: Flag checks watch channel 1 reads
`timescale 1ns/1ps
module motor_diag_regs_props
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Measurements and interrupt
	input wire logic [1:0][7:0] duty_cycle,
	input wire logic [1:0][7:0] temperature_c,
	input wire logic [1:0][15:0] supply_mv,
	input wire logic [1:0] short_detect,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Expected channel 1 flags, two stages to match read latency
	logic rd_flags;
	logic [3:0] flg_now;
	logic [7:0] flg_pipe;
	assign rd_flags = psel && !penable && !pwrite && paddr == 12'h02c;
	assign flg_now[0] = $signed(duty_cycle[0]) >= 8'sh7f || $signed(duty_cycle[0]) <= -8'sh7f;
	assign flg_now[1] = $signed(temperature_c[0]) > 8'sh50;
	assign flg_now[2] = supply_mv[0] < 16'h1b58;
	assign flg_now[3] = short_detect[0];
	// Delay line of expected flags
	always_ff @(posedge clock)
	begin
		flg_pipe <= {flg_pipe[3:0], flg_now};
	end
	// ==========================================================
	// Bus answer
	property p_ready_once;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready not one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_idle_data;
		!pready |-> prdata == 32'h0;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("prdata outside access");
	property p_unaligned;
		psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned not refused");
	property p_reset_quiet;
		disable iff (1'b0) !rst_n |=> !pready && !irq && prdata == 32'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
	// ==========================================================
	// Channel 1 flag reads
	// saturation flag
	property p_sat;
		rd_flags && $past(rst_n) |=> prdata[0] == flg_pipe[4];
	endproperty
	a_sat: assert property (p_sat) else $error("saturation flag wrong");
	property p_overtemp;
		rd_flags && $past(rst_n) |-> ##1 prdata[1] == flg_pipe[5];
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("temperature flag wrong");
	property p_undervolt;
		rd_flags && $past(rst_n) |=> pready && prdata[3] == flg_pipe[6];
	endproperty
	a_undervolt: assert property (p_undervolt) else $error("under-voltage flag wrong");
	property p_short;
		rd_flags && $past(rst_n) |=> prdata[5] == flg_pipe[7];
	endproperty
	a_short: assert property (p_short) else $error("short flag wrong");
endmodule
bind motor_diag_regs motor_diag_regs_props chk_u (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .duty_cycle(duty_cycle), .temperature_c(temperature_c),
	.supply_mv(supply_mv), .short_detect(short_detect), .irq(irq));

/* test_motor_channel_diag_status.sv */
// Purpose: Self-checking bench of the motor diagnostic register bank
// Assumes: One access cycle per APB transfer
// Notes: Flag cases sit in a table, run on both channels
`timescale 1ns/1ps
module test_motor_channel_diag_status;
	typedef struct packed
	{
		logic [7:0] d;
		logic [7:0] t;
		logic [15:0] i;
		logic [15:0] v;
		logic [2:0] s;
		logic [3:0] m;
		logic [31:0] e;
	} row_t;
	// ==========================================================
	// Design ports
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [1:0][15:0] status_word = '0;
	logic [1:0][15:0] coil_voltage = '0;
	logic [1:0][15:0] coil_current = '0;
	logic [1:0][15:0] current_limit = '0;
	logic [1:0][15:0] control_error = '0;
	logic [1:0][7:0] duty_cycle = '0;
	logic [1:0][15:0] motor_velocity = '0;
	logic [1:0][15:0] overload_time = '0;
	logic [1:0][15:0] pos_status = '0;
	logic [1:0][15:0] pos_step = '0;
	logic [1:0][15:0] pos_lag = '0;
	logic [1:0][3:0] active_mode = '0;
	logic [1:0][7:0] temperature_c = '0;
	logic [1:0][15:0] supply_mv = '0;
	logic [1:0] short_detect = '0;
	logic [1:0] stage_unpowered = '0;
	logic [1:0] init_failed = '0;
	logic perr;
	logic [31:0] rdv;
	logic [15:0] base;
	int bad_count = 0;
	int samples_checked = 0;
	// Flag cases: duty, temp, current, supply, short/unpowered/init, mode, flags
	row_t rows [17] = '{
		'{8'h00, 8'h19, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00000},
		'{8'h7f, 8'h19, 16'h0000, 16'h5dc0, 3'h0, 4'h3, 32'h30001},
		'{8'h81, 8'h19, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00001},
		'{8'h7e, 8'h19, 16'h0000, 16'h5dc0, 3'h0, 4'hf, 32'hf0000},
		'{8'h00, 8'h51, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00002},
		'{8'h00, 8'h50, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00000},
		'{8'h00, 8'h65, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00102},
		'{8'h00, 8'h64, 16'h0000, 16'h5dc0, 3'h0, 4'h0, 32'h00002},
		'{8'h00, 8'h19, 16'h03e9, 16'h5dc0, 3'h0, 4'h0, 32'h00004},
		'{8'h00, 8'h19, 16'h03e8, 16'h5dc0, 3'h0, 4'h0, 32'h00000},
		'{8'h00, 8'h19, 16'hfc17, 16'h5dc0, 3'h0, 4'h0, 32'h00004},
		'{8'h00, 8'h19, 16'h0000, 16'h1b57, 3'h0, 4'h0, 32'h00008},
		'{8'h00, 8'h19, 16'h0000, 16'h1b58, 3'h0, 4'h0, 32'h00000},
		'{8'h00, 8'h19, 16'h0000, 16'h6721, 3'h0, 4'h0, 32'h00010},
		'{8'h00, 8'h19, 16'h0000, 16'h5dc0, 3'h4, 4'h0, 32'h00020},
		'{8'h00, 8'h19, 16'h0000, 16'h5dc0, 3'h2, 4'h0, 32'h00080},
		'{8'h00, 8'h19, 16'h0000, 16'h5dc0, 3'h1, 4'h0, 32'h00100}};
	motor_diag_regs dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .status_word(status_word), .coil_voltage(coil_voltage),
		.coil_current(coil_current), .current_limit(current_limit),
		.control_error(control_error), .duty_cycle(duty_cycle),
		.motor_velocity(motor_velocity), .overload_time(overload_time),
		.pos_status(pos_status), .pos_step(pos_step), .pos_lag(pos_lag),
		.active_mode(active_mode), .temperature_c(temperature_c), .supply_mv(supply_mv),
		.short_detect(short_detect), .stage_unpowered(stage_unpowered),
		.init_failed(init_failed), .irq(irq));
	// Clock
	always #2.5 clock = ~clock;
	// ==========================================================
	// Shared tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			bad_count++;
		rdv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check(rdv, e);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task drive(input int c, input row_t x);
		@(posedge clock);
		duty_cycle[c] <= x.d;
		temperature_c[c] <= x.t;
		coil_current[c] <= x.i;
		supply_mv[c] <= x.v;
		{short_detect[c], stage_unpowered[c], init_failed[c]} <= x.s;
		active_mode[c] <= x.m;
	endtask
	task print_verdict;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#200000;
		bad_count++;
		print_verdict();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		drive(0, rows[0]);
		drive(1, rows[0]);
		repeat (9) @(posedge clock);
		// Release and first setup share an edge, step still all ones
		fork
			begin
				@(posedge clock);
				rst_n <= 1'b1;
			end
			rd(12'h024, 32'hffff);
		join
		check({31'h0, irq}, 32'h0);
		rd(12'h030, 32'h3e8);
		rd(12'h034, 32'h5dc0);
		rd(12'h088, 32'h0);
		for (int c = 0; c < 2; c++)
		begin
			for (int k = 0; k < 17; k++)
			begin
				drive(c, rows[k]);
				rd(12'(c * 64 + 44), rows[k].e);
			end
			drive(c, rows[0]);
			@(posedge clock);
			base = 16'h1a00 + 16'(c) * 16'h1000;
			status_word[c] <= base;
			coil_voltage[c] <= base + 16'h1;
			coil_current[c] <= base + 16'h2;
			current_limit[c] <= base + 16'h3;
			control_error[c] <= base + 16'h4;
			duty_cycle[c] <= 8'h05;
			motor_velocity[c] <= base + 16'h6;
			overload_time[c] <= base + 16'h7;
			pos_status[c] <= base + 16'h8;
			pos_step[c] <= base + 16'h9;
			pos_lag[c] <= base + 16'ha;
			for (int k = 0; k < 11; k++)
			begin
				wr(12'(c * 64 + k * 4), 32'hffffffff);
				rd(12'(c * 64 + k * 4), (k == 5) ? 32'h5 : {16'h0, base + 16'(k)});
			end
			drive(c, rows[0]);
		end
		// Pending and adopted configuration, overload as error
		wr(12'h030, 32'h64);
		rd(12'h02c, 32'h200);
		rd(12'h030, 32'h64);
		wr(12'h03c, 32'h1);
		rd(12'h02c, 32'h0);
		wr(12'h038, 32'h1);
		wr(12'h03c, 32'h1);
		drive(0, rows[8]);
		rd(12'h02c, 32'h104);
		wr(12'h030, 32'h3e8);
		wr(12'h038, 32'h0);
		wr(12'h03c, 32'h1);
		drive(0, rows[0]);
		// Interrupt masked, enabled, cleared
		wr(12'h088, 32'h0);
		wr(12'h084, 32'hf);
		rd(12'h080, 32'h0);
		drive(0, rows[1]);
		repeat (3) @(posedge clock);
		check({31'h0, irq}, 32'h0);
		rd(12'h080, 32'h1);
		wr(12'h088, 32'h1);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h1);
		drive(0, rows[0]);
		wr(12'h084, 32'h1);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h0);
		drive(1, rows[15]);
		// Status bit lands two edges after the input
		@(posedge clock);
		rd(12'h080, 32'h8);
		// Refused and write-only places
		rd(12'h084, 32'h0);
		xfer(12'h090, 1'b0, 32'h0);
		check({31'h0, perr}, 32'h1);
		xfer(12'h002, 1'b1, 32'h1);
		check({31'h0, perr}, 32'h1);
		print_verdict();
	end
endmodule
